// ==== design/eda_core.sv ====
/*
 * eda_core: extends 16-bit pointers into the paged data space, checks page zero,
 * paces extended reads, and keeps the software stack pointer with its limit checks.
 * assumes the core holds a request steady until done_o, and issues one at a time.
 */
`timescale 1ns/10ps

// Operation
// [RQ1] window pages are 32 Kbytes each
// [RQ2] reads use read page, writes write page
// [RQ3] page plus pointer forms 24-bit address
// [RQ4] page zero through window traps address error
// [RQ5] read: nine page bits with fifteen offset
// [RQ6] core loads page, offset, then sets bit15
// [RQ7] extended read costs one extra cycle
// [RQ8] looped reads: three, three, then one
// [RQ9] write: nine page bits with fifteen offset
// [RQ10] extended writes finish in one cycle
// [RQ11] pointer wrap never advances page registers
// [RQ12] core avoids read-modify-write inside loops
// [RQ13] read-modify-write takes read page register
// [RQ14] pointer below 8000h ignores page registers
// [RQ15] stack grows up, post-increment, pre-decrement
// [RQ16] call push clears program counter top byte
// [RQ17] exception push packs status low byte
// [RQ18] limit bit zero forced clear
// [RQ19] push at limit passes, next one traps
// [RQ20] stack pointer below 0800h traps
// [RQ21] core avoids limit write then stack read
// [RQ22] traps are one-cycle pulses, access suppressed
module eda_core
	import eda_pkg::*;
#(
	parameter int unsigned PAGE_WIDTH = PAGE_W      // page register width
)
(
	// clock and reset
	input  wire logic              REF_CLK_I,
	input  wire logic              RESET_I,
	// page register loads
	input  wire logic              RD_PAGE_WE_I,
	input  wire logic              WR_PAGE_WE_I,
	input  wire logic [9:0]        PAGE_DATA_I,
	// data access request
	input  wire eda_req_t          REQ_I,
	// stack operation request
	input  wire eda_stk_t          STK_OP_I,
	input  wire logic              STK_EXC_I,
	input  wire logic [15:0]       STK_DATA_I,
	input  wire logic [22:0]       STK_PC_I,
	input  wire logic [7:0]        STK_STATUS_LOW_I,
	// resolved access
	output eda_addr_t              ACC_O,
	output logic                   DONE_O,
	// stack results
	output logic [15:0]            SP_O,
	output logic [15:0]            STK_ADDR_O,
	output logic [15:0]            STK_LO_O,
	output logic [15:0]            STK_HI_O,
	output logic                   STK_WR_O,
	// page register view
	output logic [9:0]             RD_PAGE_O,
	output logic [9:0]             WR_PAGE_O,
	// trap events
	output logic                   ADDR_TRAP_O,
	output logic                   STK_TRAP_O
);

	initial
	begin
		if (PAGE_WIDTH != PAGE_W)
			$error("eda_core: page width must be 10");
		if (PAGE_BYTES != (1 << OFS_W))          // RQ1
			$error("eda_core: page size must match window");
	end

	// is a pointer steered into the upper window
	function automatic logic in_window(input logic [15:0] p);
		in_window = p[WIN_BIT];
	endfunction : in_window

	// page registers
	logic [9:0]  rd_page_reg, rd_page_next;   // read page select
	logic [9:0]  wr_page_reg, wr_page_next;   // write page select

	// access pacing
	logic [1:0]  wait_reg, wait_next;         // remaining stall cycles
	logic [1:0]  rpt_cnt_reg, rpt_cnt_next;   // long-form looped reads seen so far
	eda_addr_t   acc_reg, acc_next;           // registered resolved access
	logic        done_reg, done_next;         // access completion pulse
	logic        atrap_reg, atrap_next;       // address error pulse

	// stack state
	logic [15:0] sp_reg, sp_next;             // stack pointer
	logic [15:0] lim_reg, lim_next;           // stack limit value
	logic [15:0] saddr_reg, saddr_next;       // address used by last stack op
	logic [15:0] slo_reg, slo_next;           // low pushed word
	logic [15:0] shi_reg, shi_next;           // high pushed word
	logic        swr_reg, swr_next;           // stack write strobe
	logic        strap_reg, strap_next;       // stack error pulse

	// page register next values: only explicit loads change them
	always_comb
	begin
		rd_page_next = rd_page_reg;
		wr_page_next = wr_page_reg;
		if (RD_PAGE_WE_I)
			rd_page_next = PAGE_DATA_I;          // RQ11
		if (WR_PAGE_WE_I)
			wr_page_next = PAGE_DATA_I;          // RQ11
	end

	// address forming, page check and read pacing
	always_comb
	begin
		logic [9:0] pg;
		logic       is_rd;
		logic       start;
		pg           = rd_page_reg;
		is_rd        = 1'b0;
		start        = 1'b0;
		wait_next    = wait_reg;
		rpt_cnt_next = rpt_cnt_reg;
		acc_next     = '0;
		done_next    = 1'b0;
		atrap_next   = 1'b0;
		if (wait_reg != 2'd0)
		begin
			// stalling an extended read
			wait_next = wait_reg - 2'd1;
			acc_next  = acc_reg;
			acc_next.rd = 1'b0;
			if (wait_reg == 2'd1)
				done_next = 1'b1;
		end
		else if (REQ_I.kind != EDA_NONE && !done_reg)
		begin
			start = 1'b1;
			is_rd = (REQ_I.kind != EDA_WRITE);     // RQ13
			pg    = is_rd ? rd_page_reg : wr_page_reg; // RQ2
			if (!in_window(REQ_I.ptr))
			begin
				// base space, pages ignored
				acc_next.addr = {8'h00, REQ_I.ptr};   // RQ14
				acc_next.rd   = is_rd;
				acc_next.wr   = !is_rd;
				done_next     = 1'b1;
			end
			else if (pg == PAGE_ZERO)
			begin
				// page zero aliases base memory: trap, no access
				atrap_next = 1'b1;                     // RQ4 RQ22
				done_next  = 1'b1;
			end
			else
			begin
				acc_next.ext = 1'b1;
				if (is_rd && pg[PVIEW_BIT])
				begin
					// program view: eight page bits, word half select
					acc_next.pview = 1'b1;             // RQ2
					acc_next.addr  = {pg[PVIEW_SEL], pg[7:0], REQ_I.ptr[14:0]};
				end
				else
					acc_next.addr = {pg[PAGE_LOW_W-1:0], REQ_I.ptr[OFS_W-1:0]}; // RQ3 RQ5 RQ9
				acc_next.rd = is_rd;
				acc_next.wr = !is_rd;
				if (!is_rd)
					done_next = 1'b1;                  // RQ10
				else if (REQ_I.in_rpt)
				begin
					// looped reads: first two long, then single
					if (REQ_I.rpt_first)
						rpt_cnt_next = 2'd1;
					else if (rpt_cnt_reg < 2'(RPT_HEAD_N))
						rpt_cnt_next = rpt_cnt_reg + 2'd1;
					if (REQ_I.rpt_first || rpt_cnt_reg < 2'(RPT_HEAD_N))
						wait_next = 2'(RPT_CYC_HEAD - 1); // RQ8
					else
						done_next = 1'b1;              // RQ8
				end
				else
					wait_next = 2'(RD_CYC - 1);        // RQ7
			end
		end
		if (start && !REQ_I.in_rpt)
			rpt_cnt_next = 2'd0;
	end

	// stack pointer, limit and trap checks
	always_comb
	begin
		logic [15:0] dec;
		dec        = sp_reg - 16'd2;
		sp_next    = sp_reg;
		lim_next   = lim_reg;
		saddr_next = saddr_reg;
		slo_next   = slo_reg;
		shi_next   = shi_reg;
		swr_next   = 1'b0;
		strap_next = 1'b0;
		case (STK_OP_I)
			EDA_SLIM:
				lim_next = {STK_DATA_I[15:1], 1'b0};  // RQ18
			EDA_PUSH:
			begin
				saddr_next = sp_reg;
				if (sp_reg > lim_reg || sp_reg < BASE_LOW)
					strap_next = 1'b1;                 // RQ19 RQ20 RQ22
				else
				begin
					// post-increment by two words for the pc pair
					sp_next  = sp_reg + 16'd4;         // RQ15
					swr_next = 1'b1;
					slo_next = {STK_PC_I[15:1], 1'b0};
					if (STK_EXC_I)
						shi_next = {STK_STATUS_LOW_I, 1'b0, STK_PC_I[22:16]}; // RQ17
					else
						shi_next = {8'h00, 1'b0, STK_PC_I[22:16]};     // RQ16
				end
			end
			EDA_POP:
			begin
				saddr_next = dec;
				if (dec < BASE_LOW)
					strap_next = 1'b1;                 // RQ20 RQ22
				else
					sp_next = dec;                     // RQ15
			end
			default:
				;
		endcase
	end

	// register all state
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			rd_page_reg <= PAGE_RST;
			wr_page_reg <= PAGE_RST;
			wait_reg    <= 2'd0;
			rpt_cnt_reg <= 2'd0;
			acc_reg     <= '0;
			done_reg    <= 1'b0;
			atrap_reg   <= 1'b0;
			sp_reg      <= SP_RST;
			lim_reg     <= LIM_RST;
			saddr_reg   <= 16'h0000;
			slo_reg     <= 16'h0000;
			shi_reg     <= 16'h0000;
			swr_reg     <= 1'b0;
			strap_reg   <= 1'b0;
		end
		else
		begin
			rd_page_reg <= rd_page_next;
			wr_page_reg <= wr_page_next;
			wait_reg    <= wait_next;
			rpt_cnt_reg <= rpt_cnt_next;
			acc_reg     <= acc_next;
			done_reg    <= done_next;
			atrap_reg   <= atrap_next;
			sp_reg      <= sp_next;
			lim_reg     <= lim_next;
			saddr_reg   <= saddr_next;
			slo_reg     <= slo_next;
			shi_reg     <= shi_next;
			swr_reg     <= swr_next;
			strap_reg   <= strap_next;
		end
	end

	// outputs straight from flip-flops
	assign ACC_O       = acc_reg;
	assign DONE_O      = done_reg;
	assign SP_O        = sp_reg;
	assign STK_ADDR_O  = saddr_reg;
	assign STK_LO_O    = slo_reg;
	assign STK_HI_O    = shi_reg;
	assign STK_WR_O    = swr_reg;
	assign RD_PAGE_O   = rd_page_reg;
	assign WR_PAGE_O   = wr_page_reg;
	assign ADDR_TRAP_O = atrap_reg;
	assign STK_TRAP_O  = strap_reg;

	// page zero through the window traps next cycle
	chk_page_zero_trap: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ4
		(wait_reg == 2'd0 && !done_reg && REQ_I.kind == EDA_READ && REQ_I.ptr[15] && rd_page_reg == 10'h000)
		|=> ADDR_TRAP_O && !ACC_O.rd)
		else $error("page zero read did not trap");

	// plain extended read completes two cycles later
	sequence s_ext_read;
		wait_reg == 2'd0 && !done_reg && REQ_I.kind == EDA_READ && REQ_I.ptr[15]
			&& !REQ_I.in_rpt && rd_page_reg != 10'h000;
	endsequence
	chk_ext_read_cost: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ7
		s_ext_read |=> !DONE_O ##1 DONE_O)
		else $error("extended read cost wrong");

	// extended write done one cycle later with write page
	chk_ext_write_addr: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ9
		(wait_reg == 2'd0 && !done_reg && REQ_I.kind == EDA_WRITE && REQ_I.ptr[15] && wr_page_reg != 10'h000)
		|=> DONE_O && ACC_O.wr && ACC_O.addr == {$past(wr_page_reg[8:0]), $past(REQ_I.ptr[14:0])})
		else $error("extended write wrong");

	// low pointers pass through unpaged
	chk_base_direct: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ14
		(wait_reg == 2'd0 && !done_reg && REQ_I.kind != EDA_NONE && !REQ_I.ptr[15])
		|=> DONE_O && ACC_O.addr == {8'h00, $past(REQ_I.ptr)})
		else $error("base access paged");

	// read page register moves only on loads
	chk_page_hold: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ11
		!RD_PAGE_WE_I |=> $stable(RD_PAGE_O))
		else $error("read page moved");

	// limit bit zero always clear
	chk_lim_align: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ18
		lim_reg[0] == 1'b0)
		else $error("limit misaligned");

	// push beyond limit traps and keeps pointer
	chk_push_limit: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ19
		(STK_OP_I == EDA_PUSH && sp_reg > lim_reg) |=> STK_TRAP_O && $stable(SP_O) && !STK_WR_O)
		else $error("overflow not trapped");

	// pop below base traps
	chk_pop_under: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ20
		(STK_OP_I == EDA_POP && sp_reg < 16'h0802) |=> STK_TRAP_O)
		else $error("underflow not trapped");

	// call push top byte clear
	chk_call_msb: assert property (@(posedge REF_CLK_I) disable iff (RESET_I) // RQ16
		(STK_OP_I == EDA_PUSH && !STK_EXC_I && !strap_next) |=> STK_WR_O && STK_HI_O[15:8] == 8'h00)
		else $error("call push top byte set");

endmodule : eda_core

// ==== design/eda_pkg.sv ====
/*
 * eda_pkg: constants and carrier types for the extended data addressing block.
 * assumes a 16-bit core with word-aligned stack and a 24-bit paged data space.
 */
package eda_pkg;

	localparam int unsigned PTR_W        = 16;          // data pointer width
	localparam int unsigned PAGE_W       = 10;          // page register width
	localparam int unsigned EXT_ADDR_W   = 24;          // extended address width
	localparam int unsigned OFS_W        = 15;          // offset bits inside a window page
	localparam int unsigned PAGE_LOW_W   = 9;           // page bits used for extended data
	localparam int unsigned PAGE_BYTES   = 32768;       // size of one window page in bytes
	localparam int unsigned WIN_BIT      = 15;          // pointer bit steering into the window
	localparam int unsigned PVIEW_BIT    = 9;           // page bit selecting program view
	localparam int unsigned PVIEW_SEL    = 8;           // page bit picking upper program word
	localparam logic [15:0] BASE_LOW     = 16'h0800;    // lowest legal base data / stack address
	localparam logic [15:0] WIN_START    = 16'h8000;    // start of the upper data window
	localparam logic [9:0]  PAGE_ZERO    = 10'h000;     // page aliasing base memory
	localparam logic [9:0]  PAGE_RST     = 10'h001;     // page registers after reset
	localparam logic [15:0] SP_RST       = 16'h0800;    // stack pointer after reset
	localparam logic [15:0] LIM_RST      = 16'h0000;    // limit reset image (contents undefined)
	localparam int unsigned RD_CYC       = 2;           // cycles of a plain extended read
	localparam int unsigned RPT_CYC_HEAD = 3;           // cycles of first two reads in a loop
	localparam int unsigned RPT_CYC_TAIL = 1;           // cycles of later reads in a loop
	localparam int unsigned RPT_HEAD_N   = 2;           // reads in a loop that take the long form

	// kind of data access presented by the core
	typedef enum logic [1:0]
	{
		EDA_NONE  = 2'b00,
		EDA_READ  = 2'b01,
		EDA_WRITE = 2'b11,
		EDA_RMW   = 2'b10
	} eda_acc_t;

	// kind of stack operation presented by the core
	typedef enum logic [1:0]
	{
		EDA_SNONE = 2'b00,
		EDA_PUSH  = 2'b01,
		EDA_POP   = 2'b11,
		EDA_SLIM  = 2'b10
	} eda_stk_t;

	// one data access request
	typedef struct packed
	{
		eda_acc_t   kind;      // read, write or read-modify-write
		logic [15:0] ptr;      // 16-bit pointer
		logic       in_rpt;    // issued under a repeat loop
		logic       rpt_first; // first iteration of that loop
	} eda_req_t;

	// resolved address
	typedef struct packed
	{
		logic [23:0] addr;     // effective address
		logic        pview;    // program view access
		logic        ext;      // went through the window
		logic        wr;       // write strobe
		logic        rd;       // read strobe
	} eda_addr_t;

endpackage : eda_pkg

// ==== sim/eda_core_model.sv ====
/*
 * eda_core_model: load/store side of the core, issues one data request and holds it until done.
 * assumes the bench calls issue just after a rising edge of the core clock.
 */
`timescale 1ns/10ps
module eda_core_model
	import eda_pkg::*;
(
	// clock and design answers
	input  wire logic      clk_i,
	input  wire logic      done_i,
	input  wire eda_addr_t acc_i,
	input  wire logic      trap_i,
	// request toward the design
	output eda_req_t       req_o
);
	initial req_o = '0;

	// hold the request until done, count edges, keep the first resolved address and any trap
	task automatic issue(input eda_req_t r, output int n, output eda_addr_t a, output logic t);
		n = 0;
		t = 1'b0;
		a = '0;
		// read-modify-write never runs inside a loop
		if (r.kind == EDA_RMW) r.in_rpt = 1'b0;
		// pages were loaded before the pointer arrives with bit 15 set
		req_o = r;
		while (done_i !== 1'b1 && n < 8)
		begin
			@(posedge clk_i);
			#1;
			n++;
			if (n == 1) a = acc_i;
			t = t | trap_i;
		end
		// released: idle kind, pointer no longer shows the last value
		req_o = '{kind: EDA_NONE, ptr: ~r.ptr, in_rpt: 1'b0, rpt_first: 1'b0};
		@(posedge clk_i);
		#1;
	endtask : issue
endmodule : eda_core_model

// ==== sim/tb_top.sv ====
/*
 * tb_top: self-checking bench for eda_core, window addressing, traps, loop pacing and stack.
 * assumes the core model drives the data request and the bench drives pages and stack ops.
 */
`timescale 1ns/10ps
module tb_top
	import eda_pkg::*;
;
	logic        clk, rst, rd_we, wr_we, stk_exc, stk_wr, done, atrap, strap, pview_exp;
	logic [9:0]  page_d, rd_page, wr_page;
	logic [15:0] stk_data, sp, stk_addr, stk_lo, stk_hi;
	logic [22:0] stk_pc;
	logic [7:0]  stk_status_low;
	eda_req_t    req;
	eda_stk_t    stk_op;
	eda_addr_t   acc;
	int          num_errors, comparisons;

	eda_core dut_u (.REF_CLK_I(clk), .RESET_I(rst), .RD_PAGE_WE_I(rd_we), .WR_PAGE_WE_I(wr_we),
		.PAGE_DATA_I(page_d), .REQ_I(req), .STK_OP_I(stk_op), .STK_EXC_I(stk_exc), .STK_DATA_I(stk_data),
		.STK_PC_I(stk_pc), .STK_STATUS_LOW_I(stk_status_low), .ACC_O(acc), .DONE_O(done), .SP_O(sp),
		.STK_ADDR_O(stk_addr), .STK_LO_O(stk_lo), .STK_HI_O(stk_hi), .STK_WR_O(stk_wr), .RD_PAGE_O(rd_page),
		.WR_PAGE_O(wr_page), .ADDR_TRAP_O(atrap), .STK_TRAP_O(strap));
	eda_core_model model_u (.clk_i(clk), .done_i(done), .acc_i(acc), .trap_i(atrap), .req_o(req));

	// 100 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// load one page register for one cycle
	task automatic set_page(input logic wr_sel, input logic [9:0] p);
		page_d = p;
		rd_we = !wr_sel;
		wr_we = wr_sel;
		@(posedge clk);
		#1;
		rd_we = 1'b0;
		wr_we = 1'b0;
		// one idle edge so a following load never re-drives the strobes in this step
		@(posedge clk);
		#1;
	endtask : set_page

	// one data access through the model, judged on cycles, trap, address and strobe
	task automatic access(input eda_acc_t k, input logic [15:0] p, input logic rp, input logic rf,
		input int n_exp, input logic [23:0] a_exp, input logic t_exp);
		int n;
		eda_addr_t a;
		logic t;
		model_u.issue('{kind: k, ptr: p, in_rpt: rp, rpt_first: rf}, n, a, t);
		if (n >= 8)
		begin
			num_errors++;
			report_and_stop();
		end
		if (n_exp > 0) check(n, n_exp);
		check(t, t_exp);
		if (!t_exp) check(a.addr, a_exp);
		check(k == EDA_WRITE ? a.wr : a.rd, !t_exp);
		check({a.pview, a.ext}, {pview_exp, p[15] && !t_exp});
	endtask : access

	// one stack operation, results are seen in the following cycle
	task automatic stk(input eda_stk_t op, input logic exc);
		@(posedge clk);
		#1;
		stk_op = op;
		stk_exc = exc;
		@(posedge clk);
		#1;
		stk_op = EDA_SNONE;
	endtask : stk

	task automatic t_window();
		set_page(1'b0, 10'h002);
		set_page(1'b1, 10'h005);
		access(EDA_READ, 16'h8800, 1'b0, 1'b0, 2, 24'h01_0800, 1'b0);
		access(EDA_WRITE, 16'h8800, 1'b0, 1'b0, 1, 24'h02_8800, 1'b0);
		access(EDA_RMW, 16'h8800, 1'b1, 1'b1, 2, 24'h01_0800, 1'b0);
		access(EDA_READ, 16'h1234, 1'b0, 1'b0, 1, 24'h00_1234, 1'b0);
		access(EDA_WRITE, 16'h7FFE, 1'b0, 1'b0, 1, 24'h00_7FFE, 1'b0);
		access(EDA_READ, 16'hFFFE, 1'b0, 1'b0, 2, 24'h01_7FFE, 1'b0);
		access(EDA_READ, 16'h8000, 1'b0, 1'b0, 2, 24'h01_0000, 1'b0);
		check(rd_page, 10'h002);
		check(wr_page, 10'h005);
		set_page(1'b0, 10'h305);
		pview_exp = 1'b1;
		access(EDA_READ, 16'h8004, 1'b0, 1'b0, 0, 24'h82_8004, 1'b0);
		pview_exp = 1'b0;
		$display("test window done");
	endtask : t_window

	task automatic t_page_zero();
		set_page(1'b0, 10'h000);
		set_page(1'b1, 10'h000);
		access(EDA_READ, 16'h8000, 1'b0, 1'b0, 1, 24'h00_0000, 1'b1);
		access(EDA_WRITE, 16'h9000, 1'b0, 1'b0, 1, 24'h00_0000, 1'b1);
		access(EDA_READ, 16'h0800, 1'b0, 1'b0, 1, 24'h00_0800, 1'b0);
		$display("test page zero done");
	endtask : t_page_zero

	task automatic t_repeat();
		set_page(1'b0, 10'h003);
		for (int i = 0; i < 4; i++)
			access(EDA_READ, 16'h8000 + 16'(2 * i), 1'b1, i == 0, i < 2 ? 3 : 1, 24'h01_8000 + 24'(2 * i), 1'b0);
		$display("test repeat done");
	endtask : t_repeat

	task automatic t_stack();
		stk_data = 16'h0809;
		stk(EDA_SLIM, 1'b0);
		@(posedge clk);
		stk(EDA_PUSH, 1'b0);
		check({sp, stk_addr}, 32'h0804_0800);
		check({stk_wr, strap}, 2'b10);
		check({stk_lo, stk_hi}, 32'hBCDE_005A);
		stk(EDA_PUSH, 1'b1);
		check({sp, stk_hi}, 32'h0808_C35A);
		stk(EDA_PUSH, 1'b0);
		check({sp, stk_addr}, 32'h080C_0808);
		stk(EDA_PUSH, 1'b0);
		check({stk_wr, strap, sp}, {2'b01, 16'h080C});
		stk(EDA_POP, 1'b0);
		check({sp, stk_addr}, 32'h080A_080A);
		@(posedge clk);
		#1;
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		stk(EDA_POP, 1'b0);
		check({strap, sp}, {1'b1, 16'h0800});
		$display("test stack done");
	endtask : t_stack

	initial
	begin
		{rd_we, wr_we, stk_exc, pview_exp, page_d, stk_data} = '0;
		stk_op = EDA_SNONE;
		stk_pc = 23'h5A_BCDF;
		stk_status_low = 8'hC3;
		rst = 1'b1;
		num_errors = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		check({rd_page, wr_page}, {10'h001, 10'h001});
		check({sp, done, atrap, strap, stk_wr}, {16'h0800, 4'h0});
		t_window();
		t_page_zero();
		t_repeat();
		t_stack();
		report_and_stop();
	end
endmodule : tb_top
